// file: rtl/pia_arbiter.sv
/*
 Prioritized interrupt arbiter top: level settings, protected vector
 table base, and the winning request presented to the processor.
 Assumes peripheral request lines are synchronous levels (flag and enable).
*/
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Fixed vector; address is base plus 4*vector
// - Vectors 0-3, 22 and 27-31 have no source
// - Vector base resets to 0x8000
// - Base low eight bits always zero
// - Base writable only after key 0x0096
// - Three-bit level per source, 7 highest
// - All levels reset to zero
// - Present request, level and vector
// - Highest level wins
// - Equal level: smallest vector wins
// - Losers stay pending and compete later
// - Higher arrival replaces presented request
// - Cleared peripheral flag withdraws request
// - Non-maskable request line stays low
module pia_arbiter
	import pia_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [PIA_NUM_VEC-1:0] src_req_in,
	input wire logic [PIA_ADDR_W-1:0] reg_addr_in,
	input wire logic [PIA_DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [PIA_DATA_W-1:0] reg_rdata_out,
	output logic irq_req_out,
	output logic [PIA_LVL_W-1:0] irq_level_out,
	output logic [PIA_VEC_W-1:0] irq_vector_out,
	output logic [23:0] irq_vec_addr_out,
	output logic nmi_req_out
);
	localparam logic [PIA_NUM_VEC-1:0] SRC_MASK = 32'h07bffff0;

	typedef struct packed {
		logic [15:0] prot;
		logic [23:8] base;
		logic [PIA_DATA_W-1:0] rdata;
		logic [2:0] rsel;
	} pia_top_s;

	localparam logic [2:0] RS_NONE = 3'h0;
	localparam logic [2:0] RS_PROT = 3'h1;
	localparam logic [2:0] RS_LO = 3'h2;
	localparam logic [2:0] RS_HI = 3'h3;
	localparam logic [2:0] RS_STAT = 3'h4;
	localparam logic [2:0] RS_LVL = 3'h5;

	pia_top_s st_r, st_nxt;
	logic [PIA_NUM_VEC*3-1:0] lvl_all;
	logic [PIA_NUM_VEC*3/2-1:0] lvl_even;
	logic [PIA_NUM_VEC*3/2-1:0] lvl_odd;
	logic [2:0] even_rdata;
	logic [2:0] odd_rdata;
	logic [PIA_NUM_VEC-1:0] req_live;
	logic win_any;
	logic [2:0] win_lvl;
	logic [4:0] win_vec;
	logic lvl_hit;
	logic [4:0] lvl_idx;
	logic lvl_wr;
	logic [7:0] lvl_ofs;

	// Two levels per half-word register, low vector in bits 2:0
	always_comb
	begin
		lvl_ofs = reg_addr_in - PIA_OFS_LVL0;
		lvl_hit = reg_addr_in >= PIA_OFS_LVL0 && lvl_ofs < 8'h20 && !reg_addr_in[0];
		lvl_idx = {1'b0, lvl_ofs[4:1]};
	end
	assign lvl_wr = reg_wr_in && lvl_hit;

	// No latching here: a cleared flag drops its request the same cycle
	assign req_live = src_req_in & SRC_MASK;

	pia_pick u_pick (
		.req_in(req_live),
		.lvl_in(lvl_all),
		.any_out(win_any),
		.lvl_out(win_lvl),
		.vec_out(win_vec)
	);

	// One store per field, so one register write sets both halves at once
	pia_level_mem #(
		.DEPTH(PIA_NUM_VEC / 2)
	) u_lvl_even (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.wr_in(lvl_wr),
		.waddr_in(lvl_idx),
		.wdata_in(reg_wdata_in[PIA_LVL_W-1:0]),
		.raddr_in(lvl_idx),
		.rdata_out(even_rdata),
		.all_out(lvl_even)
	);

	pia_level_mem #(
		.DEPTH(PIA_NUM_VEC / 2)
	) u_lvl_odd (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.wr_in(lvl_wr),
		.waddr_in(lvl_idx),
		.wdata_in(reg_wdata_in[PIA_LVL_HI_POS +: PIA_LVL_W]),
		.raddr_in(lvl_idx),
		.rdata_out(odd_rdata),
		.all_out(lvl_odd)
	);

	// Interleave both stores back into per-vector order
	for (genvar g = 0; g < PIA_NUM_VEC / 2; g++)
	begin : g_lvl_pair
		assign lvl_all[g*6 +: 3] = lvl_even[g*3 +: 3];
		assign lvl_all[g*6+3 +: 3] = lvl_odd[g*3 +: 3];
	end

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rsel = RS_NONE;
		if (reg_wr_in)
		begin
			case (reg_addr_in)
				PIA_OFS_PROT: st_nxt.prot = reg_wdata_in;
				PIA_OFS_BASE_LO:
				begin
					if (st_r.prot == PIA_PROT_KEY)
						st_nxt.base[15:8] = reg_wdata_in[15:PIA_BASE_LO_POS];
				end
				PIA_OFS_BASE_HI:
				begin
					if (st_r.prot == PIA_PROT_KEY)
						st_nxt.base[23:16] = reg_wdata_in[7:0];
				end
				default: ;
			endcase
		end
		if (reg_rd_in)
		begin
			case (reg_addr_in)
				PIA_OFS_PROT: st_nxt.rsel = RS_PROT;
				PIA_OFS_BASE_LO: st_nxt.rsel = RS_LO;
				PIA_OFS_BASE_HI: st_nxt.rsel = RS_HI;
				PIA_OFS_STATUS: st_nxt.rsel = RS_STAT;
				default: st_nxt.rsel = lvl_hit ? RS_LVL : RS_NONE;
			endcase
		end
		case (st_nxt.rsel)
			RS_PROT: st_nxt.rdata = st_r.prot;
			RS_LO: st_nxt.rdata = {st_r.base[15:8], 8'h00};
			RS_HI: st_nxt.rdata = {8'h00, st_r.base[23:16]};
			RS_STAT: st_nxt.rdata = {win_any, 4'h0, win_lvl, 3'h0, win_vec};
			default: st_nxt.rdata = 16'h0000;
		endcase
	end

	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			st_r.prot <= PIA_PROT_RST;
			st_r.base <= PIA_BASE_RST[23:8];
			st_r.rdata <= 16'h0000;
			st_r.rsel <= RS_NONE;
		end
		else
			st_r <= st_nxt;
	end

	// Level read data arrive from the memory register in the same cycle
	always_comb
	begin
		reg_rdata_out = st_r.rdata;
		if (st_r.rsel == RS_LVL)
			reg_rdata_out = {5'h00, odd_rdata, 5'h00, even_rdata};
	end

	// Presented outputs follow the live winner every cycle; a level-zero
	// winner is still shown but the processor will not take it
	assign irq_req_out = win_any;
	assign irq_level_out = win_lvl;
	assign irq_vector_out = win_vec;
	assign irq_vec_addr_out = {st_r.base, 8'h00} + {17'h0, win_vec, 2'b00};
	assign nmi_req_out = 1'b0;
endmodule // pia_arbiter
`default_nettype wire

// file: rtl/pia_pkg.sv
/*
 Package for the prioritized interrupt arbiter: register offsets, field
 positions, reset values and vector numbering.
 Assumes a single 200 MHz system clock and a plain register port.
*/
package pia_pkg;
	localparam int PIA_NUM_VEC = 32;
	localparam int PIA_FIRST_SRC = 4;
	localparam int PIA_LAST_SRC = 26;
	localparam int PIA_EMPTY_SRC = 22;
	localparam int PIA_LVL_W = 3;
	localparam int PIA_VEC_W = 5;
	localparam int PIA_ADDR_W = 8;
	localparam int PIA_DATA_W = 16;
	localparam logic [7:0] PIA_OFS_PROT = 8'h00;
	localparam logic [7:0] PIA_OFS_BASE_LO = 8'h02;
	localparam logic [7:0] PIA_OFS_BASE_HI = 8'h04;
	localparam logic [7:0] PIA_OFS_STATUS = 8'h06;
	localparam logic [7:0] PIA_OFS_LVL0 = 8'h10;
	localparam logic [15:0] PIA_PROT_KEY = 16'h0096;
	localparam logic [15:0] PIA_PROT_RST = 16'h0000;
	localparam logic [23:0] PIA_BASE_RST = 24'h008000;
	localparam int PIA_BASE_LO_POS = 8;
	localparam int PIA_LVL_HI_POS = 8;
	localparam int PIA_VEC_SHIFT = 2;
	localparam logic [2:0] PIA_LVL_RST = 3'h0;
endpackage

// file: rtl/pia_level_mem.sv
/*
 Small memory of per-vector level settings with registered read data.
 Assumes one clock; writes and reads come from the register port.
*/
`timescale 1ns/100ps
`default_nettype none
module pia_level_mem
	import pia_pkg::*;
#(
	parameter int DEPTH = PIA_NUM_VEC
)(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic wr_in,
	input wire logic [4:0] waddr_in,
	input wire logic [2:0] wdata_in,
	input wire logic [4:0] raddr_in,
	output logic [2:0] rdata_out,
	output logic [DEPTH*3-1:0] all_out
);
	// Elaboration-time refusal of depths the 5-bit address cannot serve
	if (DEPTH < 1 || DEPTH > PIA_NUM_VEC)
	begin : g_bad_depth
		$error("pia_level_mem: depth out of range");
	end
	typedef struct packed {
		logic [DEPTH-1:0][2:0] lvl;
		logic [2:0] rd;
	} pia_mem_s;
	pia_mem_s st_r, st_nxt;
	always_comb
	begin
		st_nxt = st_r;
		if (wr_in && 32'(waddr_in) < DEPTH)
			st_nxt.lvl[waddr_in] = wdata_in;
		st_nxt.rd = (32'(raddr_in) < DEPTH) ? st_r.lvl[raddr_in] : 3'h0;
	end
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
	assign rdata_out = st_r.rd;
	assign all_out = st_r.lvl;
endmodule // pia_level_mem
`default_nettype wire

// file: rtl/pia_pick.sv
/*
 Combinational winner search over level-tagged requests.
 Assumes levels are held stable by the caller's registers.
*/
`timescale 1ns/100ps
`default_nettype none
module pia_pick
	import pia_pkg::*;
(
	input wire logic [PIA_NUM_VEC-1:0] req_in,
	input wire logic [PIA_NUM_VEC*3-1:0] lvl_in,
	output logic any_out,
	output logic [2:0] lvl_out,
	output logic [4:0] vec_out
);
	always_comb
	begin
		any_out = 1'b0;
		lvl_out = 3'h0;
		vec_out = 5'h00;
		// Walking up, only a strictly higher level displaces: low vector wins ties
		for (int i = 0; i < PIA_NUM_VEC; i++)
		begin
			if (req_in[i] && (!any_out || lvl_in[i*3 +: 3] > lvl_out))
			begin
				any_out = 1'b1;
				lvl_out = lvl_in[i*3 +: 3];
				vec_out = 5'(i);
			end
		end
	end
endmodule // pia_pick
`default_nettype wire

// file: bench/pia_arbiter_asserts.sv
/* Port checker for the interrupt arbiter.
 Bound to pia_arbiter; sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
module pia_chk (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [31:0] src_req_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic irq_req_out,
	input wire logic [2:0] irq_level_out,
	input wire logic [4:0] irq_vector_out,
	input wire logic [23:0] irq_vec_addr_out,
	input wire logic nmi_req_out
);
	logic open_r;
	wire logic bw = reg_wr_in && reg_addr_in == 8'h02;
	always_ff @(posedge sys_clk_in or posedge rst_in)
		if (rst_in)
			open_r <= 1'b0;
		else if (reg_wr_in && reg_addr_in == 8'h00)
			open_r <= reg_wdata_in == 16'h0096;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	AST_NMI: assert property (!nmi_req_out) else $error("nmi");
	AST_REQ: assert property (irq_req_out == |(src_req_in & 32'h07bffff0))
		else $error("req");
	AST_VSRC: assert property (irq_req_out |-> src_req_in[irq_vector_out]
		&& irq_vector_out inside {[4:21], [23:26]}) else $error("vec");
	AST_ADDR: assert property (irq_vec_addr_out[7:0] ==
		{1'b0, irq_vector_out, 2'b00}) else $error("addr");
	AST_RST: assert property ($fell(rst_in) |->
		irq_vec_addr_out[23:8] == 16'h0080) else $error("rst");
	AST_LOCK: assert property (bw && !open_r |=>
		$stable(irq_vec_addr_out[23:8])) else $error("lock");
	AST_OPEN: assert property (bw && open_r |=> irq_vec_addr_out[15:8] ==
		$past(reg_wdata_in[15:8])) else $error("open");
	AST_RDB: assert property (reg_rd_in && reg_addr_in == 8'h02 |=>
		reg_rdata_out == {irq_vec_addr_out[15:8], 8'h00}) else $error("rd");
	AST_HOLD: assert property ($stable(src_req_in) && !$past(reg_wr_in) |->
		$stable(irq_vector_out)) else $error("hold");
	cover property (irq_req_out && irq_level_out == 3'h7);
	cover property (bw && open_r);
	cover property (irq_req_out ##1 irq_req_out && $changed(irq_vector_out));
endmodule // pia_chk
bind pia_arbiter pia_chk i_chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
	.src_req_in(src_req_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .irq_req_out(irq_req_out),
	.irq_level_out(irq_level_out), .irq_vector_out(irq_vector_out),
	.irq_vec_addr_out(irq_vec_addr_out), .nmi_req_out(nmi_req_out));
`default_nettype wire

// file: bench/pia_core_model.sv
/* Processor core model taking presented requests.
 Assumes arbiter outputs settle before each rising edge. */
`timescale 1ns/100ps
`default_nettype none
module pia_core_model (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic req_in,
	input wire logic [2:0] level_in,
	input wire logic ei_in,
	input wire logic swi_in,
	input wire logic [2:0] swi_lvl_in,
	output logic ack_out
);
	logic ie_r;
	logic [2:0] thr_r;
	// Level 0 never exceeds threshold, so never taken
	assign ack_out = req_in && ie_r && level_in > thr_r;
	always_ff @(posedge sys_clk_in or posedge rst_in)
		if (rst_in)
			{ie_r, thr_r} <= 4'h0;
		else if (ei_in)
			{ie_r, thr_r} <= 4'h8;
		else if (swi_in)
			{ie_r, thr_r} <= {1'b0, swi_lvl_in};
		else if (ack_out)
			{ie_r, thr_r} <= {1'b0, level_in};
endmodule // pia_core_model
`default_nettype wire

// file: bench/prioritized_interrupt_arbiter_bench.sv
/* Self-checking bench for the interrupt arbiter.
 Assumes pia_core_model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module prioritized_interrupt_arbiter_bench;
	import pia_pkg::*;
	localparam logic [31:0] SRC_MASK = 32'h07bffff0;
	logic sys_clk, rst, wr, rd, ei, ack, req, nmi, swi;
	logic [31:0] src;
	logic [7:0] addr;
	logic [15:0] wd, rdat;
	logic [2:0] lvl, slv;
	logic [4:0] vec, v;
	logic [23:0] vaddr;
	int fail_count, n_tests, lv[32], base, i, k, n, e, wl, wv;
	pia_arbiter i_dut (.sys_clk_in(sys_clk), .rst_in(rst), .src_req_in(src),
		.reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdat), .irq_req_out(req), .irq_level_out(lvl),
		.irq_vector_out(vec), .irq_vec_addr_out(vaddr), .nmi_req_out(nmi));
	pia_core_model i_core (.sys_clk_in(sys_clk), .rst_in(rst), .req_in(req),
		.level_in(lvl), .ei_in(ei), .swi_in(swi), .swi_lvl_in(slv),
		.ack_out(ack));
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		{addr, wd, wr} <= {a, d, 1'b1};
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		{addr, rd} <= {a, 1'b1};
		@(posedge sys_clk);
		rd <= 1'b0;
		@(negedge sys_clk);
		cmp(rdat, d);
	endtask
	// Reference winner: highest level, then lowest vector
	task automatic chk_irq;
		int bl, bv;
		@(negedge sys_clk);
		bl = -1;
		bv = 0;
		for (int j = 31; j >= 0; j--)
			if (src[j] && SRC_MASK[j] && lv[j] >= bl)
			begin
				bl = lv[j];
				bv = j;
			end
		wl = bl;
		wv = bv;
		cmp(nmi, 0);
		cmp(req, 32'(bl >= 0));
		if (bl >= 0)
		begin
			cmp({vec, lvl}, 32'(bv * 8 + bl));
			cmp(vaddr, 32'(base + 4 * bv));
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		{rst, wr, rd, ei, src, addr, wd} = {4'h8, 32'h0, 8'h0, 16'h0};
		base = 'h8000;
		{swi, slv} = 4'h0;
		void'($urandom(32'hb6a3df7c));
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		rd_reg(PIA_OFS_BASE_LO, 16'h8000);
		rd_reg(8'hf0, 16'h0000);
		for (k = 0; k < 16; k++)
			rd_reg(PIA_OFS_LVL0 + 8'(2 * k), 16'h0000);
		wr_reg(PIA_OFS_BASE_LO, 16'h1234);
		rd_reg(PIA_OFS_BASE_LO, 16'h8000);
		wr_reg(PIA_OFS_PROT, PIA_PROT_KEY);
		wr_reg(PIA_OFS_BASE_LO, 16'h12ff);
		wr_reg(PIA_OFS_BASE_HI, 16'h0034);
		rd_reg(PIA_OFS_BASE_LO, 16'h1200);
		wr_reg(PIA_OFS_PROT, 16'h0095);
		wr_reg(PIA_OFS_BASE_HI, 16'h0000);
		rd_reg(PIA_OFS_BASE_HI, 16'h0034);
		base = 'h341200;
		$display("register test done");
		for (i = 0; i < 300; i++)
		begin
			k = $urandom_range(15);
			lv[2 * k] = $urandom_range(7);
			lv[2 * k + 1] = $urandom_range(7);
			e = lv[2 * k + 1] * 256 + lv[2 * k];
			@(posedge sys_clk);
			src <= 32'h0;
			wr_reg(PIA_OFS_LVL0 + 8'(2 * k), 16'(e));
			rd_reg(PIA_OFS_LVL0 + 8'(2 * k), 16'(e));
			@(posedge sys_clk);
			src <= $urandom;
			chk_irq();
			e = (wl < 0) ? 0 : 32768 + wl * 256 + wv;
			rd_reg(PIA_OFS_STATUS, 16'(e));
		end
		$display("arbitration test done");
		@(posedge sys_clk);
		{src, ei} <= {SRC_MASK, 1'b1};
		@(posedge sys_clk);
		{ei, swi, slv} <= {1'b0, 1'b1, 3'h7};
		@(posedge sys_clk);
		swi <= 1'b0;
		@(negedge sys_clk);
		cmp(ack, 0);
		@(posedge sys_clk);
		ei <= 1'b1;
		@(posedge sys_clk);
		ei <= 1'b0;
		n = 0;
		for (i = 0; i < 400; i++)
		begin
			chk_irq();
			if (ack === 1'b1)
			begin
				n++;
				v = vec;
				@(posedge sys_clk);
				src[v] <= 1'b0;
				ei <= 1'b1;
				@(posedge sys_clk);
				ei <= 1'b0;
			end
		end
		e = 0;
		foreach (lv[j])
			e += SRC_MASK[j] && lv[j] > 0;
		cmp(n, e);
		$display("acceptance test done");
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd_reg(PIA_OFS_BASE_HI, 16'h0000);
		rd_reg(PIA_OFS_BASE_LO, 16'h8000);
		rd_reg(PIA_OFS_LVL0 + 8'(2 * k), 16'h0000);
		$display("reset test done");
		complete_run();
	end
endmodule // prioritized_interrupt_arbiter_bench
`default_nettype wire
